// >>> tig_pkg.sv
package tig_pkg;

  // ----------------------------------------------------------------------
  // widths and register offsets
  // ----------------------------------------------------------------------
  localparam int         TIG_CNT_W       = 16;
  localparam int         TIG_NUM_CHAN    = 4;
  localparam int         TIG_NUM_SRC     = 5;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_CONTROL    = 8'h08;
  localparam logic [7:0] ADDR_COUNTER    = 8'h0c;
  localparam logic [7:0] ADDR_GR_BASE    = 8'h10;
  localparam logic [7:0] ADDR_GR_STEP    = 8'h04;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         BIT_OVERFLOW    = 7;
  localparam int         BIT_RSVD_LSB    = 4;
  localparam int         CTRL_RUN_BIT    = 0;
  localparam int         CTRL_MODE_LSB   = 4;
  localparam logic [2:0] RSVD_READ_VALUE = 3'h7;
  localparam logic [4:0] IRQ_ENABLE_RST  = 5'h00;
  localparam logic [3:0] MODE_RST        = 4'h0;
  localparam logic       RUN_RST         = 1'h0;
  localparam int         SRC_OVERFLOW    = 4;

  // ----------------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tig_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tig_apb_rsp_t;

  typedef struct packed {
    logic overflow_irq_request;
    logic chan_d_irq_request;
    logic chan_c_irq_request;
    logic chan_b_irq_request;
    logic chan_a_irq_request;
  } tig_irq_t;

  typedef enum logic {
    FLAG_IDLE  = 1'b0,
    FLAG_ARMED = 1'b1
  } tig_arm_state_t;

endpackage

// >>> tig_flag_cell.sv
`timescale 1ns/10ps
module tig_flag_cell (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic set_evt,
  input  wire logic rd_evt,
  input  wire logic wr_evt,
  input  wire logic wr_bit,
  output logic      flag,
  output logic      armed
);
  import tig_pkg::*;

  typedef struct packed {
    logic           flag;
    tig_arm_state_t arm;
  } tig_cell_state_t;

  tig_cell_state_t st_reg;
  tig_cell_state_t st_next;

  // ----------------------------------------------------------------------
  // read-then-write-zero clear, set has priority
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (rd_evt && st_reg.flag) begin
      st_next.arm = FLAG_ARMED;
    end
    if (wr_evt) begin
      case (st_reg.arm)
        FLAG_ARMED: begin
          if (!wr_bit) begin
            st_next.flag = 1'b0;
          end
        end
        FLAG_IDLE: begin
          st_next.flag = st_reg.flag;
        end
        default: begin
          st_next.flag = st_reg.flag;
        end
      endcase
      st_next.arm = FLAG_IDLE;
    end
    if (set_evt) begin
      st_next.flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '{flag: 1'b0, arm: FLAG_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag  = st_reg.flag;
  assign armed = (st_reg.arm == FLAG_ARMED);

endmodule

// >>> tig_timer_irq_gate.sv
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
module tig_timer_irq_gate #(
  parameter int CNT_W = tig_pkg::TIG_CNT_W
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire tig_pkg::tig_apb_req_t  apb_req,
  output tig_pkg::tig_apb_rsp_t       apb_rsp,
  input  wire logic [3:0]             capture_in,
  output tig_pkg::tig_irq_t           irq
);
  import tig_pkg::*;

  typedef struct packed {
    tig_apb_rsp_t          rsp;
    tig_irq_t              irq;
    logic [4:0]            irq_enable;
    logic                  run;
    logic [3:0]            mode;
    logic [CNT_W-1:0]      timer_counter;
    logic [3:0][CNT_W-1:0] general_reg;
  } tig_state_t;

  tig_state_t st_reg;
  tig_state_t st_next;
  logic [4:0] flag;
  logic [4:0] armed;
  logic [4:0] evt;
  logic [4:0] wr_bits;
  logic       setup;
  logic       access;
  logic       rd_stat;
  logic       wr_stat;
  logic       wr_cnt;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] target);
    reg_hit = (a == target);
  endfunction

  function automatic logic [7:0] gr_addr(input int idx);
    gr_addr = ADDR_GR_BASE + 8'(idx) * ADDR_GR_STEP;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic m;
    m = reg_hit(a, ADDR_IRQ_ENABLE) || reg_hit(a, ADDR_STATUS) ||
        reg_hit(a, ADDR_CONTROL) || reg_hit(a, ADDR_COUNTER);
    for (int i = 0; i < TIG_NUM_CHAN; i++) begin
      m = m || reg_hit(a, gr_addr(i));
    end
    is_mapped = m;
  endfunction

  assign setup   = apb_req.psel && !apb_req.penable;
  assign access  = apb_req.psel && apb_req.penable && st_reg.rsp.pready;
  assign rd_stat = access && !apb_req.pwrite &&
                   reg_hit(apb_req.paddr, ADDR_STATUS);
  assign wr_stat = access && apb_req.pwrite &&
                   reg_hit(apb_req.paddr, ADDR_STATUS);
  assign wr_cnt  = access && apb_req.pwrite &&
                   reg_hit(apb_req.paddr, ADDR_COUNTER);
  assign wr_bits = {apb_req.pwdata[BIT_OVERFLOW], apb_req.pwdata[3:0]};

  // ----------------------------------------------------------------------
  // flag events
  // ----------------------------------------------------------------------
  // wrap detect
  assign evt[SRC_OVERFLOW] = st_reg.run && !wr_cnt &&
                             (st_reg.timer_counter == {CNT_W{1'b1}});

  genvar g;
  generate
    for (g = 0; g < TIG_NUM_CHAN; g++) begin : g_chan
      assign evt[g] = st_reg.mode[g] ? capture_in[g] :
                      (st_reg.run && st_reg.timer_counter ==
                       st_reg.general_reg[g]);
    end
    for (g = 0; g < TIG_NUM_SRC; g++) begin : g_flag
      tig_flag_cell u_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set_evt (evt[g]),
        .rd_evt  (rd_stat),
        .wr_evt  (wr_stat),
        .wr_bit  (wr_bits[g]),
        .flag    (flag[g]),
        .armed   (armed[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next             = st_reg;
    st_next.rsp.pready  = setup;
    st_next.rsp.pslverr = setup && !is_mapped(apb_req.paddr);
    st_next.rsp.prdata  = 32'h0;
    if (setup && !apb_req.pwrite) begin
      case (apb_req.paddr)
        ADDR_IRQ_ENABLE: st_next.rsp.prdata = {24'h0,
          st_reg.irq_enable[SRC_OVERFLOW], RSVD_READ_VALUE,
          st_reg.irq_enable[3:0]};
        ADDR_STATUS: st_next.rsp.prdata = {24'h0, flag[SRC_OVERFLOW],
          RSVD_READ_VALUE, flag[3:0]};
        ADDR_CONTROL: st_next.rsp.prdata = {24'h0, st_reg.mode, 3'h0,
          st_reg.run};
        ADDR_COUNTER: st_next.rsp.prdata = 32'(st_reg.timer_counter);
        default: begin
          for (int i = 0; i < TIG_NUM_CHAN; i++) begin
            if (reg_hit(apb_req.paddr, gr_addr(i))) begin
              st_next.rsp.prdata = 32'(st_reg.general_reg[i]);
            end
          end
        end
      endcase
    end
    if (access && apb_req.pwrite) begin
      if (reg_hit(apb_req.paddr, ADDR_IRQ_ENABLE)) begin
        st_next.irq_enable = wr_bits;
      end
      if (reg_hit(apb_req.paddr, ADDR_CONTROL)) begin
        st_next.run  = apb_req.pwdata[CTRL_RUN_BIT];
        st_next.mode = apb_req.pwdata[CTRL_MODE_LSB +: 4];
      end
      for (int i = 0; i < TIG_NUM_CHAN; i++) begin
        if (reg_hit(apb_req.paddr, gr_addr(i))) begin
          st_next.general_reg[i] = apb_req.pwdata[CNT_W-1:0];
        end
      end
    end
    if (wr_cnt) begin
      st_next.timer_counter = apb_req.pwdata[CNT_W-1:0];
    end else if (st_reg.run) begin
      st_next.timer_counter = st_reg.timer_counter + 1'b1;
    end
    for (int i = 0; i < TIG_NUM_CHAN; i++) begin
      if (st_reg.mode[i] && capture_in[i]) begin
        st_next.general_reg[i] = st_reg.timer_counter;
      end
    end
    st_next.irq.overflow_irq_request =
      flag[SRC_OVERFLOW] && st_reg.irq_enable[SRC_OVERFLOW];
    st_next.irq.chan_d_irq_request = flag[3] && st_reg.irq_enable[3];
    st_next.irq.chan_c_irq_request = flag[2] && st_reg.irq_enable[2];
    st_next.irq.chan_b_irq_request = flag[1] && st_reg.irq_enable[1];
    st_next.irq.chan_a_irq_request = flag[0] && st_reg.irq_enable[0];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg            <= '0;
      st_reg.irq_enable <= IRQ_ENABLE_RST;
      st_reg.run        <= RUN_RST;
      st_reg.mode       <= MODE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp = st_reg.rsp;
  assign irq     = st_reg.irq;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_rd_enable_setup;
    setup && !apb_req.pwrite && apb_req.paddr == ADDR_IRQ_ENABLE;
  endsequence
  sequence s_read_flag_set;
    rd_stat && flag[0];
  endsequence
  sequence s_write_zero;
    wr_stat && !wr_bits[0] && !evt[0];
  endsequence

  property p_ovf_req;
    1'b1 |=> irq.overflow_irq_request ==
             $past(flag[SRC_OVERFLOW] && st_reg.irq_enable[SRC_OVERFLOW]);
  endproperty
  a_ovf_req: assert property (p_ovf_req)
    else $error("overflow request not gated by flag and enable");
  property p_d_req;
    1'b1 |=> irq.chan_d_irq_request == $past(flag[3] && st_reg.irq_enable[3]);
  endproperty
  a_d_req: assert property (p_d_req)
    else $error("channel d request not gated");
  property p_c_req;
    1'b1 |=> irq.chan_c_irq_request == $past(flag[2] && st_reg.irq_enable[2]);
  endproperty
  a_c_req: assert property (p_c_req)
    else $error("channel c request not gated");
  property p_b_req;
    1'b1 |=> irq.chan_b_irq_request == $past(flag[1] && st_reg.irq_enable[1]);
  endproperty
  a_b_req: assert property (p_b_req)
    else $error("channel b request not gated");
  property p_a_req;
    1'b1 |=> irq.chan_a_irq_request == $past(flag[0] && st_reg.irq_enable[0]);
  endproperty
  a_a_req: assert property (p_a_req)
    else $error("channel a request not gated");
  property p_rsvd_read;
    s_rd_enable_setup |=> apb_rsp.pready && apb_rsp.prdata[6:4] == 3'h7;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved enable bits did not read as one");
  property p_enable_reset;
    disable iff (1'b0) rst |=> st_reg.irq_enable == 5'h00 && irq == '0;
  endproperty
  a_enable_reset: assert property (p_enable_reset)
    else $error("enables not cleared by reset");
  property p_flag_when_disabled;
    evt[0] && !st_reg.irq_enable[0]
      |=> flag[0] && !irq.chan_a_irq_request;
  endproperty
  a_flag_when_disabled: assert property (p_flag_when_disabled)
    else $error("disabled source lost its flag or raised request");
  property p_wrap;
    st_reg.run && !wr_cnt && st_reg.timer_counter == {CNT_W{1'b1}}
      |=> flag[SRC_OVERFLOW] && st_reg.timer_counter == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not set overflow flag");
  property p_clear_after_read;
    s_read_flag_set ##1 (!wr_stat [*2]) ##1 s_write_zero |=> !flag[0];
  endproperty
  a_clear_after_read: assert property (p_clear_after_read)
    else $error("flag did not clear after read then write zero");
  property p_no_clear_unarmed;
    wr_stat && !armed[0] && flag[0] |=> flag[0];
  endproperty
  a_no_clear_unarmed: assert property (p_no_clear_unarmed)
    else $error("flag cleared without prior read");
  property p_capture;
    st_reg.mode[0] && capture_in[0]
      |=> flag[0] && st_reg.general_reg[0] == $past(st_reg.timer_counter);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not load value and set flag");

endmodule

// >>> tig_irq_sink.sv
`timescale 1ns/10ps
module tig_irq_sink (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire tig_pkg::tig_irq_t irq,
  output logic [4:0]             seen
);
  import tig_pkg::*;

  // ----------------------------------------------------------------------
  // cpu side: sticky record of every request line seen
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen <= 5'h00;
    end else begin
      seen <= seen | irq;
    end
  end
endmodule

// >>> tig_timer_irq_gate_test.sv
`timescale 1ns/10ps
module tig_timer_irq_gate_test;
  import tig_pkg::*;
  logic         ref_clk    = 1'b0;
  logic         rst        = 1'b1;
  tig_apb_req_t apb_req    = '0;
  tig_apb_rsp_t apb_rsp;
  logic [3:0]   capture_in = 4'h0;
  tig_irq_t     irq;
  logic [4:0]   seen;
  int           errors     = 0;
  int           cmp_count  = 0;
  logic [31:0]  rd;
  logic [31:0]  cnt;
  logic         er;
  logic [7:0]   row_w [5]  = '{8'hff, 8'h00, 8'h81, 8'h0a, 8'h84};
  logic [7:0]   row_rd [5] = '{8'hff, 8'h70, 8'hf1, 8'h7a, 8'hf4};
  logic [4:0]   row_irq [5] = '{5'h1f, 5'h00, 5'h11, 5'h0a, 5'h14};

  tig_timer_irq_gate tig_timer_irq_gate_inst (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .apb_req    (apb_req),
    .apb_rsp    (apb_rsp),
    .capture_in (capture_in),
    .irq        (irq)
  );

  tig_irq_sink tig_irq_sink_inst (
    .ref_clk (ref_clk),
    .rst     (rst),
    .irq     (irq),
    .seen    (seen)
  );

  always #4 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    test_done;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_IRQ_ENABLE, 32'h0);
    chk(rd, 32'h70);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h70);
    chk({27'h0, irq}, 32'h0);
    $display("test reset done");
    apb(1'b1, ADDR_GR_BASE, 32'h2);
    apb(1'b1, ADDR_COUNTER, 32'hfffd);
    apb(1'b1, ADDR_CONTROL, 32'he1);
    repeat (8) @(posedge ref_clk);
    apb(1'b1, ADDR_CONTROL, 32'he0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'hf1);
    apb(1'b0, ADDR_COUNTER, 32'h0);
    cnt = rd;
    capture_in <= 4'he;
    @(posedge ref_clk);
    capture_in <= 4'h0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'hff);
    apb(1'b0, ADDR_GR_BASE + ADDR_GR_STEP, 32'h0);
    chk(rd, cnt);
    chk({27'h0, irq}, 32'h0);
    chk({27'h0, seen}, 32'h0);
    $display("test flags done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_IRQ_ENABLE, {24'h0, row_w[i]});
      apb(1'b0, ADDR_IRQ_ENABLE, 32'h0);
      chk(rd, {24'h0, row_rd[i]});
      @(posedge ref_clk);
      chk({27'h0, irq}, {27'h0, row_irq[i]});
    end
    chk({27'h0, seen}, 32'h1f);
    $display("test enables done");
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h8f);
    apb(1'b1, ADDR_STATUS, 32'hff);
    apb(1'b1, ADDR_STATUS, 32'h00);
    repeat (3) @(posedge ref_clk);
    chk({27'h0, irq}, 32'h1f);
    apb(1'b0, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hfe);
    repeat (3) @(posedge ref_clk);
    chk({27'h0, irq}, 32'h1e);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'hfe);
    $display("test clear done");
    apb(1'b1, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, ADDR_IRQ_ENABLE, 32'h0);
    chk(rd, 32'hff);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test unmapped done");
    // channel a as capture, counter stopped at cnt
    apb(1'b1, ADDR_CONTROL, 32'h10);
    capture_in <= 4'h1;
    @(posedge ref_clk);
    capture_in <= 4'h0;
    apb(1'b0, ADDR_GR_BASE, 32'h0);
    chk(rd, cnt);
    chk({27'h0, irq}, 32'h1f);
    $display("test capture done");
    test_done;
  end
endmodule
